// ---- core/uart_register_address_decoder.sv ----
// Summary of operation
// - An access is decoded only while the active-low chip select is low, location from the three address bits.
// - With divisor access clear, location 0 reads rx holding and writes tx holding.
// - With divisor access set, locations 0 and 1 are the read/write divisor low and high bytes.
// - With divisor access set and divisor zero, reads of 0 and 1 give revision and device id codes.
// - With divisor access clear, location 1 is the read/write interrupt enable register.
// - With line control not 0xbf, location 2 reads interrupt status and writes fifo control.
// - Location 3 always reaches line control.
// - With line control not 0xbf, location 4 is the read/write modem control register.
// - In the standard bank location 5 reads line status and ignores writes.
// - Location 6 reads modem status, levels high nibble and change flags low nibble.
// - With line control not 0xbf, location 7 is a read/write scratch byte.
// - With line control 0xbf, location 2 is the read/write enhanced function register.
// - With line control 0xbf, locations 4 to 7 write the two resume and two suspend characters.
// - Extended bits of enable, status, fifo control and modem control act only while enhanced bit 4 is set.
// - Reset clears all four flow-control characters.
`timescale 1ns/100ps
`default_nettype none
`include "uart_regs_defines.svh"
module uart_register_address_decoder (
  input  wire logic                      I_CLK,
  input  wire logic                      I_RST_N,
  input  wire uart_regs_pkg::bus_req_t   I_BUS,
  input  wire uart_regs_pkg::core_stat_t I_STAT,
  output logic [7:0]                     O_RDATA,
  output logic                           O_TX_LOAD,
  output logic [7:0]                     O_TX_DATA,
  output logic                           O_RX_POP,
  output logic                           O_FIFO_CTL_WR,
  output logic [7:0]                     O_FIFO_CTL,
  output logic [15:0]                    O_DIVISOR,
  output logic [7:0]                     O_INT_EN,
  output logic [7:0]                     O_LINE_CTL,
  output logic [7:0]                     O_MODEM_CTL,
  output logic [7:0]                     O_ENH_FUNC,
  output logic [31:0]                    O_FLOW_CHARS
);
  import uart_regs_pkg::*;

  // ----------------------------------------
  // reset release and bus input sync
  // ----------------------------------------
  // bus strobes come from the host, outside this clock
  logic [1:0] rst_sync_r;
  logic       rst_n;
  bus_req_t   bus_s1_r;
  bus_req_t   bus_s2_r;
  logic       rd_prev_r;
  logic       wr_prev_r;
  logic       rd_act;
  logic       wr_act;

  // release the reset through two flops
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // two-flop sync of every bus pin
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_s1_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, wdata: 8'h00};
      bus_s2_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, wdata: 8'h00};
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
    end
    else
    begin
      bus_s1_r  <= I_BUS;
      bus_s2_r  <= bus_s1_r;
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic       rd_go;
  logic       wr_go;
  logic [2:0] loc;
  bank_t      bank;
  logic [7:0] line_ctl_r;
  logic [7:0] div_lo_r;
  logic [7:0] div_hi_r;
  logic [7:0] int_en_r;
  logic [7:0] modem_ctl_r;
  logic [7:0] enh_func_r;
  logic [7:0] scratch_r;
  logic [7:0] fifo_ctl_r;
  logic [7:0] flow_r [4];
  logic       enh_on;
  logic       div_zero;

  // one access per strobe assertion, edge taken after sync
  assign rd_act = !bus_s2_r.cs_n && !bus_s2_r.rd_n;
  assign wr_act = !bus_s2_r.cs_n && !bus_s2_r.wr_n;
  assign rd_go  = rd_act && !rd_prev_r;
  assign wr_go  = wr_act && !wr_prev_r;
  assign loc    = bus_s2_r.addr;
  assign enh_on = enh_func_r[`ENH_ENABLE_BIT];
  assign div_zero = (div_lo_r == `BYTE_ZERO) && (div_hi_r == `BYTE_ZERO);

  // bank select: 0xbf beats the divisor bit, since 0xbf has bit 7 set
  always_comb
  begin
    if (line_ctl_r == `ENH_BANK_VAL)
      bank = BANK_ENH;
    else if (line_ctl_r[`DIV_ACCESS_BIT])
      bank = BANK_DIV;
    else
      bank = BANK_STD;
  end

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  // line control, always reachable so software can leave any bank
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      line_ctl_r <= 8'h00;
    else if (wr_go && loc == `LOC_LINE_CTL)
      line_ctl_r <= bus_s2_r.wdata;
  end

  // divisor bytes whenever the divisor bit is set, so the 0xbf bank reaches them too
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_lo_r <= 8'h00;
      div_hi_r <= 8'h00;
    end
    else if (wr_go && line_ctl_r[`DIV_ACCESS_BIT])
    begin
      if (loc == `LOC_HOLD)
        div_lo_r <= bus_s2_r.wdata;
      if (loc == `LOC_INT_EN)
        div_hi_r <= bus_s2_r.wdata;
    end
  end

  // standard bank control registers; extended bits dropped on write while disabled, masked again on use
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_en_r    <= 8'h00;
      modem_ctl_r <= 8'h00;
      scratch_r   <= 8'h00;
      fifo_ctl_r  <= 8'h00;
    end
    else if (wr_go && bank != BANK_ENH)
    begin
      if (loc == `LOC_INT_EN && bank == BANK_STD)
        int_en_r <= bus_s2_r.wdata & (enh_on ? 8'hff : `INT_EN_STD_MASK);
      if (loc == `LOC_MODEM_CTL)
        modem_ctl_r <= bus_s2_r.wdata & (enh_on ? 8'hff : `MODEM_CTL_STD_MASK);
      if (loc == `LOC_SCRATCH)
        scratch_r <= bus_s2_r.wdata;
      if (loc == `LOC_INT_STAT)
        fifo_ctl_r <= bus_s2_r.wdata & (enh_on ? 8'hff : `FIFO_CTL_STD_MASK);
    end
  end

  // enhanced function register, enhanced bank only
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
      enh_func_r <= 8'h00;
    else if (wr_go && bank == BANK_ENH && loc == `LOC_INT_STAT)
      enh_func_r <= bus_s2_r.wdata;
  end

  // flow characters, one per location 4..7
  for (genvar g = 0; g < 4; g++)
  begin : g_flow
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
      if (!rst_n)
        flow_r[g] <= 8'h00;
      else if (wr_go && bank == BANK_ENH && loc == 3'(`LOC_MODEM_CTL + g))
        flow_r[g] <= bus_s2_r.wdata;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rd_nxt;
  logic       pop_nxt;

  always_comb
  begin
    rd_nxt  = 8'h00;
    pop_nxt = 1'b0;
    case (loc)
      `LOC_HOLD:
      begin
        if (bank == BANK_STD)
        begin
          rd_nxt  = I_STAT.rx_data;
          pop_nxt = 1'b1;
        end
        else
          rd_nxt = div_zero ? `REV_CODE_VAL : div_lo_r;
      end
      `LOC_INT_EN:
      begin
        if (bank == BANK_STD)
          rd_nxt = int_en_r;
        else
          rd_nxt = div_zero ? `DEV_ID_VAL : div_hi_r;
      end
      `LOC_INT_STAT:
      begin
        if (bank == BANK_ENH)
          rd_nxt = enh_func_r;
        else
          rd_nxt = I_STAT.int_status & (enh_on ? 8'hff : `INT_STAT_STD_MASK);
      end
      `LOC_LINE_CTL:   rd_nxt = line_ctl_r;
      `LOC_MODEM_CTL:  rd_nxt = (bank == BANK_ENH) ? 8'h00 : modem_ctl_r;
      `LOC_LINE_STAT:  rd_nxt = (bank == BANK_ENH) ? 8'h00 : I_STAT.line_status;
      `LOC_MODEM_STAT: rd_nxt = I_STAT.modem_status;
      `LOC_SCRATCH:    rd_nxt = (bank == BANK_ENH) ? 8'h00 : scratch_r;
      default:         rd_nxt = 8'h00;
    endcase
  end

  // read data registered on the access edge, held until the next read
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_RDATA  <= 8'h00;
      O_RX_POP <= 1'b0;
    end
    else
    begin
      O_RX_POP <= rd_go && pop_nxt;
      if (rd_go)
        O_RDATA <= rd_nxt;
    end
  end

  // write pulses to the transmitter and fifo logic
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_TX_LOAD     <= 1'b0;
      O_TX_DATA     <= 8'h00;
      O_FIFO_CTL_WR <= 1'b0;
    end
    else
    begin
      O_TX_LOAD     <= wr_go && bank == BANK_STD && loc == `LOC_HOLD;
      O_FIFO_CTL_WR <= wr_go && bank != BANK_ENH && loc == `LOC_INT_STAT;
      if (wr_go && bank == BANK_STD && loc == `LOC_HOLD)
        O_TX_DATA <= bus_s2_r.wdata;
    end
  end

  // control copies to the core; extended bits forced low while disabled
  always_ff @(posedge I_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_DIVISOR    <= 16'h0000;
      O_INT_EN     <= 8'h00;
      O_LINE_CTL   <= 8'h00;
      O_MODEM_CTL  <= 8'h00;
      O_ENH_FUNC   <= 8'h00;
      O_FIFO_CTL   <= 8'h00;
      O_FLOW_CHARS <= 32'h0000_0000;
    end
    else
    begin
      O_DIVISOR    <= {div_hi_r, div_lo_r};
      O_INT_EN     <= int_en_r & (enh_on ? 8'hff : `INT_EN_STD_MASK);
      O_LINE_CTL   <= line_ctl_r;
      O_MODEM_CTL  <= modem_ctl_r & (enh_on ? 8'hff : `MODEM_CTL_STD_MASK);
      O_ENH_FUNC   <= enh_func_r;
      O_FIFO_CTL   <= fifo_ctl_r & (enh_on ? 8'hff : `FIFO_CTL_STD_MASK);
      O_FLOW_CHARS <= {flow_r[3], flow_r[2], flow_r[1], flow_r[0]};
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_wr_loc(logic [2:0] l);
    wr_go && loc == l;
  endsequence

  a_line_ctl_lands: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wr_loc(`LOC_LINE_CTL) |=> line_ctl_r == $past(bus_s2_r.wdata))
    else $error("line control write lost");
  a_cs_gates_load: assert property (@(posedge I_CLK) disable iff (!rst_n)
    O_TX_LOAD |-> !$past(bus_s2_r.cs_n))
    else $error("load without chip select");
  a_tx_load_bank: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wr_loc(`LOC_HOLD) && bank == BANK_STD |=> O_TX_LOAD ##1 !O_TX_LOAD)
    else $error("tx load pulse wrong");
  a_div_low_write: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wr_loc(`LOC_HOLD) && bank == BANK_DIV |=> div_lo_r == $past(bus_s2_r.wdata) ##1 O_DIVISOR[7:0] == div_lo_r)
    else $error("divisor low not written");
  a_dev_id_read: assert property (@(posedge I_CLK) disable iff (!rst_n)
    rd_go && loc == `LOC_INT_EN && bank == BANK_DIV && div_zero |=> O_RDATA == `DEV_ID_VAL)
    else $error("device id not returned");
  a_enh_bank_write: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wr_loc(`LOC_INT_STAT) && bank == BANK_ENH |=> enh_func_r == $past(bus_s2_r.wdata) && !O_FIFO_CTL_WR)
    else $error("enhanced write misrouted");
  a_flow_char_write: assert property (@(posedge I_CLK) disable iff (!rst_n)
    s_wr_loc(`LOC_SCRATCH) && bank == BANK_ENH |=> flow_r[3] == $past(bus_s2_r.wdata) && scratch_r == $past(scratch_r))
    else $error("suspend char write misrouted");
  a_ext_bits_gated: assert property (@(posedge I_CLK) disable iff (!rst_n)
    !enh_on && !$past(enh_on) |-> O_INT_EN[7:4] == 4'h0 && O_MODEM_CTL[7:5] == 3'h0)
    else $error("extended bits leak");
  a_wo_read_zero: assert property (@(posedge I_CLK) disable iff (!rst_n)
    rd_go && bank == BANK_ENH && loc >= `LOC_MODEM_CTL && loc != `LOC_MODEM_STAT |=> O_RDATA == 8'h00 && !O_RX_POP)
    else $error("write-only read not zero");
  a_modem_stat_read: assert property (@(posedge I_CLK) disable iff (!rst_n)
    rd_go && loc == `LOC_MODEM_STAT |=> O_RDATA == $past(I_STAT.modem_status))
    else $error("modem status not returned");
endmodule : uart_register_address_decoder
`default_nettype wire

// ---- core/uart_regs_defines.svh ----
`ifndef UART_REGS_DEFINES_SVH
`define UART_REGS_DEFINES_SVH
// ----------------------------------------
// register locations
// ----------------------------------------
`define LOC_HOLD        3'h0
`define LOC_INT_EN      3'h1
`define LOC_INT_STAT    3'h2
`define LOC_LINE_CTL    3'h3
`define LOC_MODEM_CTL   3'h4
`define LOC_LINE_STAT   3'h5
`define LOC_MODEM_STAT  3'h6
`define LOC_SCRATCH     3'h7
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define DIV_ACCESS_BIT 7
`define ENH_ENABLE_BIT      4
`define ENH_BANK_VAL        8'hbf
`define INT_EN_STD_MASK     8'h0f
`define INT_STAT_STD_MASK   8'hcf
`define FIFO_CTL_STD_MASK   8'hcf
`define MODEM_CTL_STD_MASK  8'h1f
`define BYTE_ZERO      8'h00
// arbitrary identity values
`define REV_CODE_VAL   8'h01
`define DEV_ID_VAL     8'h5a
`endif

// ---- core/uart_regs_pkg.sv ----
`default_nettype none
package uart_regs_pkg;
  // host bus request carried as one struct
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [2:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  // state supplied by the uart core
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] int_status;
    logic [7:0] line_status;
    logic [7:0] modem_status;
  } core_stat_t;
  typedef enum logic [1:0] {BANK_STD, BANK_DIV, BANK_ENH} bank_t;
endpackage : uart_regs_pkg
`default_nettype wire

// ---- test/uart_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// host bus master on the 8-bit parallel bus
// ----------------------------------------
module uart_host_model (
  input  wire logic                   i_clk,
  input  wire logic [7:0]             i_rdata,
  output var  uart_regs_pkg::bus_req_t o_bus
);
  import uart_regs_pkg::*;

  // idle: strobes high, chip not selected
  initial o_bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: 3'h0, wdata: 8'h00};

  // strobe held 6 clocks so sync, edge detect and register all land before the sample;
  // released lines show inverted values so no stale address or data is mistaken for live
  task automatic xfer(input logic cs_n, input logic wr, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk);
    o_bus <= '{cs_n: cs_n, rd_n: wr, wr_n: ~wr, addr: a, wdata: d};
    repeat (6) @(posedge i_clk);
    q = i_rdata;
    o_bus <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr: ~a, wdata: ~d};
    repeat (4) @(posedge i_clk);
  endtask : xfer
endmodule : uart_host_model
`default_nettype wire

// ---- test/uart_register_address_decoder_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "uart_regs_defines.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module uart_register_address_decoder_tb_top;
  import uart_regs_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  core_stat_t stat = '{rx_data: 8'ha5, int_status: 8'hff, line_status: 8'h61, modem_status: 8'h9c};
  bus_req_t   bus;
  logic [7:0] rdata, tx_data, fifo_ctl, int_en, line_ctl, modem_ctl, enh_func;
  logic [15:0] divisor;
  logic [31:0] flow;
  logic       tx_load, rx_pop, fifo_ctl_wr;
  int         errors = 0, comparisons = 0, txn = 0, popn = 0, fifo_wrn = 0;

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // design, host and pulse counters
  // ----------------------------------------
  uart_register_address_decoder dut (.I_CLK(clk), .I_RST_N(rst_n), .I_BUS(bus), .I_STAT(stat),
    .O_RDATA(rdata), .O_TX_LOAD(tx_load), .O_TX_DATA(tx_data), .O_RX_POP(rx_pop),
    .O_FIFO_CTL_WR(fifo_ctl_wr), .O_FIFO_CTL(fifo_ctl), .O_DIVISOR(divisor), .O_INT_EN(int_en),
    .O_LINE_CTL(line_ctl), .O_MODEM_CTL(modem_ctl), .O_ENH_FUNC(enh_func), .O_FLOW_CHARS(flow));
  uart_host_model host (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

  // pulses counted so a doubled or missing strobe shows up
  always @(posedge clk)
  begin
    if (tx_load === 1'b1) txn++;
    if (rx_pop === 1'b1) popn++;
    if (fifo_ctl_wr === 1'b1) fifo_wrn++;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b0, 1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer(1'b0, 1'b0, a, 8'h00, q);
    `CHK("rdata", e, q)
  endtask : rd

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_std;
    logic [7:0] q;
    wr(`LOC_LINE_CTL, 8'h03);
    `CHK("line_ctl", 8'h03, line_ctl)
    rd(`LOC_LINE_CTL, 8'h03);
    rd(`LOC_HOLD, 8'ha5);
    `CHK("popn", 1, popn)
    wr(`LOC_HOLD, 8'h3c);
    `CHK("tx_data", 8'h3c, tx_data)
    `CHK("txn", 1, txn)
    wr(`LOC_INT_EN, 8'hff);
    `CHK("int_en", 8'h0f, int_en)
    rd(`LOC_INT_EN, 8'h0f);
    rd(`LOC_INT_STAT, 8'hcf);
    wr(`LOC_INT_STAT, 8'hff);
    `CHK("fifo_ctl", 8'hcf, fifo_ctl)
    `CHK("fifo_wrn", 1, fifo_wrn)
    wr(`LOC_MODEM_CTL, 8'hff);
    `CHK("modem_ctl", 8'h1f, modem_ctl)
    rd(`LOC_MODEM_CTL, 8'h1f);
    wr(`LOC_LINE_STAT, 8'h00);
    rd(`LOC_LINE_STAT, 8'h61);
    rd(`LOC_MODEM_STAT, 8'h9c);
    wr(`LOC_SCRATCH, 8'h5a);
    rd(`LOC_SCRATCH, 8'h5a);
    // deselected write must leave the scratch byte alone
    host.xfer(1'b1, 1'b1, `LOC_SCRATCH, 8'h11, q);
    rd(`LOC_SCRATCH, 8'h5a);
  endtask : t_std

  task automatic t_div;
    wr(`LOC_LINE_CTL, 8'h80);
    rd(`LOC_HOLD, `REV_CODE_VAL);
    rd(`LOC_INT_EN, `DEV_ID_VAL);
    wr(`LOC_HOLD, 8'h34);
    wr(`LOC_INT_EN, 8'h12);
    `CHK("divisor", 16'h1234, divisor)
    rd(`LOC_HOLD, 8'h34);
    rd(`LOC_INT_EN, 8'h12);
    `CHK("txn", 1, txn)
    `CHK("popn", 1, popn)
  endtask : t_div

  task automatic t_enh;
    wr(`LOC_LINE_CTL, `ENH_BANK_VAL);
    wr(`LOC_INT_STAT, 8'h10);
    `CHK("enh_func", 8'h10, enh_func)
    rd(`LOC_INT_STAT, 8'h10);
    `CHK("fifo_wrn", 1, fifo_wrn)
    for (int i = 0; i < 4; i++) wr(3'(4 + i), 8'(17 * (i + 1)));
    `CHK("flow", 32'h44332211, flow)
    `CHK("modem_ctl", 8'h1f, modem_ctl)
    rd(`LOC_MODEM_CTL, 8'h00);
    rd(`LOC_LINE_STAT, 8'h00);
    rd(`LOC_MODEM_STAT, 8'h9c);
    rd(`LOC_LINE_CTL, 8'hbf);
    // the divisor bit is set in the 0xbf bank, so the low byte stays reachable
    wr(`LOC_HOLD, 8'h78);
    `CHK("divisor", 16'h1278, divisor)
    rd(`LOC_HOLD, 8'h78);
    `CHK("txn", 1, txn)
    wr(`LOC_LINE_CTL, 8'h00);
    wr(`LOC_INT_EN, 8'h30);
    `CHK("int_en", 8'h30, int_en)
    rd(`LOC_INT_STAT, 8'hff);
    wr(`LOC_INT_STAT, 8'hff);
    `CHK("fifo_ctl", 8'hff, fifo_ctl)
    `CHK("fifo_wrn", 2, fifo_wrn)
    wr(`LOC_MODEM_CTL, 8'he0);
    `CHK("modem_ctl", 8'he0, modem_ctl)
  endtask : t_enh

  // second reset in mid-run must wipe the flow characters
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("flow", 32'h0, flow)
    `CHK("line_ctl", 8'h00, line_ctl)
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // the bus must answer again after a mid-run reset
    rd(`LOC_MODEM_STAT, 8'h9c);
  endtask : t_reset

  task automatic results;
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_std();
    t_div();
    t_enh();
    t_reset();
    results();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end
endmodule : uart_register_address_decoder_tb_top
`default_nettype wire
